// ### hdl/opfield_pkg.sv
// Package: instruction field layouts, encodings and timing constants
package opfield_pkg;

    // ------------------------------------------------------------
    // Word and field geometry
    // ------------------------------------------------------------
    localparam int WORD_W        = 14;
    localparam int FILE_ADDR_W   = 7;
    localparam int BIT_NUM_LSB   = 7;
    localparam int DEST_BIT      = 7;
    localparam int PTR_OFS_N_BIT = 6;
    localparam int PTR_INC_N_BIT = 2;
    localparam int OSC_PER_CYCLE = 4;

    // Reset values
    localparam logic [13:0] WORD_RESET = 14'h0000;
    localparam logic [1:0]  PHASE_RESET = 2'h0;

    // Pointer update modes
    typedef enum logic [1:0] {
        PRE_INC  = 2'b00,
        PRE_DEC  = 2'b01,
        POST_INC = 2'b10,
        POST_DEC = 2'b11
    } ptr_mode_e;

    // Instruction classes
    typedef enum logic [3:0] {
        CLS_BYTE    = 4'h0,
        CLS_BIT     = 4'h1,
        CLS_LIT8    = 4'h2,
        CLS_JUMP11  = 4'h3,
        CLS_BRA9    = 4'h4,
        CLS_PAGE7   = 4'h5,
        CLS_BANK5   = 4'h6,
        CLS_PTROFS  = 4'h7,
        CLS_PTRINC  = 4'h8,
        CLS_CTRL    = 4'h9
    } instr_class_e;

    // Decoded fields of one word
    typedef struct packed {
        instr_class_e cls;
        logic [6:0]   file_addr;
        logic [2:0]   bit_num;
        logic [7:0]   bit_mask;
        logic         dest_file;
        logic         rd_file;
        logic         wr_file;
        logic         wr_acc;
        logic         ptr_sel;
        ptr_mode_e    ptr_mode;
        logic [10:0]  literal;
        logic         two_cycle;
        logic         extra_cycle;
    } decoded_s;

    // Whole state of the decoder
    typedef struct packed {
        logic [1:0]  phase;
        decoded_s    dec;
        logic        nop_cycle;
    } dec_state_s;

endpackage

// ### hdl/opcode_field_decoder.sv
// Module: operand field decoder for 14-bit instruction words
//
// Operation
// - File operand instructions read, modify, then write to chosen target.
// - Addressed register is read, even for write-only instructions, except in the Clear-W form.
// - Destination bit 0 writes accumulator, 1 writes addressed register.
// - Register address is a 7-bit offset, 0x00 to 0x7F in a bank.
// - Bit-number field selects exactly one bit of the 8-bit register.
// - Don't-care bits never affect decoding.
// - Pointer field selects one of two pointers and indirect ports.
// - Two-bit mode picks pre/post increment/decrement of pointer.
// - Each instruction is one 14-bit word with opcode and operands.
// - One instruction cycle spans four oscillator clocks.
// - Branch or true skip takes two cycles, second is a no-op.
// - Indirect access with pointer msb set adds one cycle; with a branch or true skip, only one no-op is inserted.
`timescale 1ns/1ps
`default_nettype none

module opcode_field_decoder (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    // Fetched word
    input  wire logic [13:0]            instr_word,
    input  wire logic                   skip_true,
    input  wire logic                   ptr0_msb,
    input  wire logic                   ptr1_msb,
    // Decoded fields
    output logic                        cycle_strobe,
    output opfield_pkg::decoded_s       decoded,
    output logic                        nop_cycle
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_sync1;
    logic rst_n;

    // Two-stage reset release
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1 <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n     <= rst_sync1;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    opfield_pkg::dec_state_s state;
    opfield_pkg::dec_state_s next_state;
    opfield_pkg::decoded_s   d;
    logic [13:0]             w;
    logic                    ind_access;
    logic                    ind_ptr;

    // Combinational decode of one word
    always_comb begin
        w = instr_word;
        d = '0;
        d.file_addr = w[opfield_pkg::FILE_ADDR_W-1:0];
        d.bit_num   = w[opfield_pkg::BIT_NUM_LSB +: 3];
        d.bit_mask  = 8'h01 << d.bit_num;
        d.ptr_mode  = opfield_pkg::ptr_mode_e'(w[1:0]);
        d.ptr_sel   = w[opfield_pkg::PTR_INC_N_BIT];
        d.cls       = opfield_pkg::CLS_CTRL;
        if (w[13:12] == 2'b01) begin
            d.cls     = opfield_pkg::CLS_BIT;
            d.rd_file = 1'b1;
            d.wr_file = ~w[11];
            d.two_cycle = w[11] & skip_true;
        end else if (w[13:11] == 3'b100 || w[13:11] == 3'b101) begin
            d.cls       = opfield_pkg::CLS_JUMP11;
            d.literal   = w[10:0];
            d.two_cycle = 1'b1;
        end else if (w[13:9] == 5'b11001) begin
            d.cls       = opfield_pkg::CLS_BRA9;
            d.literal   = {2'b00, w[8:0]};
            d.two_cycle = 1'b1;
        end else if (w[13:7] == 7'b1100011) begin
            d.cls     = opfield_pkg::CLS_PAGE7;
            d.literal = {4'h0, w[6:0]};
        end else if (w[13:7] == 7'b1100010) begin
            d.cls     = opfield_pkg::CLS_PTROFS;
            d.ptr_sel = w[opfield_pkg::PTR_OFS_N_BIT];
            d.literal = {5'h00, w[5:0]};
        end else if (w[13:12] == 2'b11) begin
            d.cls     = opfield_pkg::CLS_LIT8;
            d.literal = {3'h0, w[7:0]};
        end else if (w[13:5] == 9'h001) begin
            d.cls     = opfield_pkg::CLS_BANK5;
            d.literal = {6'h00, w[4:0]};
        end else if (w[13:3] == 11'h002) begin
            d.cls     = opfield_pkg::CLS_PTRINC;
        end else if (w[13:8] == 6'h00 && !w[7]) begin
            d.cls       = opfield_pkg::CLS_CTRL;
            d.two_cycle = (w[6:0] == 7'h0a) || (w[6:0] == 7'h0b)
                          || (w[6:0] == 7'h08) || (w[6:0] == 7'h09);
        end else begin
            // Byte-oriented: opcode 13:8, d bit 7, address 6:0
            d.cls       = opfield_pkg::CLS_BYTE;
            d.dest_file = w[opfield_pkg::DEST_BIT];
            d.rd_file   = 1'b1;
            d.wr_file   = d.dest_file;
            d.wr_acc    = ~d.dest_file;
            // Clear-W form ignores its low don't-care bits
            if (w[13:8] == 6'h01 && !w[7]) begin
                d.file_addr = 7'h00;
                d.rd_file   = 1'b0;
            end
            d.two_cycle = (w[11:8] == 4'hb || w[11:8] == 4'hf)
                          && !w[12] && skip_true;
        end
        // Indirect port is address 0 or 1
        ind_access = (d.cls == opfield_pkg::CLS_BYTE
                      || d.cls == opfield_pkg::CLS_BIT)
                     && d.file_addr[6:1] == 6'h00;
        ind_ptr = d.file_addr[0] ? ptr1_msb : ptr0_msb;
        d.extra_cycle = ind_access && ind_ptr;
    end

    // ------------------------------------------------------------
    // Instruction cycle sequencing
    // ------------------------------------------------------------
    // Four clocks per cycle; latch decode at end of phase 3
    always_comb begin
        next_state = state;
        next_state.phase = state.phase + 2'd1;
        if (state.phase == 2'(opfield_pkg::OSC_PER_CYCLE - 1)) begin
            next_state.phase = opfield_pkg::PHASE_RESET;
            if (state.nop_cycle) begin
                next_state.nop_cycle = 1'b0;
                next_state.dec = '0;
            end else begin
                next_state.dec = d;
                next_state.nop_cycle = d.two_cycle | d.extra_cycle;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs
    assign decoded      = state.dec;
    assign nop_cycle    = state.nop_cycle;
    assign cycle_strobe = (state.phase == opfield_pkg::PHASE_RESET);

endmodule

`default_nettype wire

// ### verif/fetch_model.sv
// Program memory model handing over one word per cycle
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
    // Clock, phase 0 marker, queued and fetched word
    input  wire logic        core_clk,
    input  wire logic        cycle_strobe,
    input  wire logic [13:0] next_word,
    output var  logic [13:0] instr_word
);
    // Whole word changes once per cycle, after phase 0
    always @(posedge core_clk) if (cycle_strobe) instr_word <= next_word;
endmodule
`default_nettype wire

// ### verif/opcode_field_decoder_monitor.sv
// Concurrent checks on the decoder outputs
`timescale 1ns/1ps
`default_nettype none
module opcode_field_decoder_monitor (
    // Clock, reset and decoder outputs
    input wire logic                  core_clk,
    input wire logic                  arst_n,
    input wire logic                  cycle_strobe,
    input wire opfield_pkg::decoded_s decoded,
    input wire logic                  nop_cycle
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence quiet_three; !cycle_strobe [*3]; endsequence
    strobe_gap_a: assert property ($fell(cycle_strobe) |-> quiet_three
        ##1 cycle_strobe) else $error("strobe gap");
    word_hold_a: assert property (!cycle_strobe |-> $stable(decoded))
        else $error("decoded moved");
    sequence nop_next; ##4 (decoded == '0 && !nop_cycle); endsequence
    nop_follow_a: assert property (cycle_strobe
        && (decoded.two_cycle || decoded.extra_cycle) |-> nop_cycle
        ##0 nop_next) else $error("no nop");
    nop_once_a: assert property (cycle_strobe && nop_cycle
        |-> ##4 !nop_cycle) else $error("double nop");
    read_first_a: assert property (decoded.wr_file |-> decoded.rd_file)
        else $error("write without read");
    dest_sel_a: assert property (decoded.cls == opfield_pkg::CLS_BYTE
        && decoded.rd_file |-> decoded.wr_file == decoded.dest_file)
        else $error("dest");
    bit_mask_a: assert property (decoded.cls == opfield_pkg::CLS_BIT
        |-> decoded.bit_mask == 8'h01 << decoded.bit_num)
        else $error("bit mask");
    jump_two_a: assert property (decoded.cls == opfield_pkg::CLS_JUMP11
        |-> decoded.two_cycle) else $error("jump one cycle");
endmodule
bind opcode_field_decoder opcode_field_decoder_monitor u_monitor (.core_clk,
    .arst_n, .cycle_strobe, .decoded, .nop_cycle);
`default_nettype wire

// ### verif/opcode_field_decoder_tb_top.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ps
`default_nettype none
module opcode_field_decoder_tb_top;
    logic        core_clk = 1'b0, arst_n = 1'b0, ptr0_msb = 1'b0;
    logic        ptr1_msb = 1'b0, cycle_strobe, nop_cycle;
    logic        skip_true = 1'b0;
    logic [13:0] next_word = 14'h3000, instr_word;
    int          failures = 0, compares = 0;
    opfield_pkg::decoded_s decoded;
    // Core clock, 25 ns period
    always #12.5 core_clk = ~core_clk;
    opcode_field_decoder dut (.core_clk, .arst_n, .instr_word,
        .skip_true, .ptr0_msb, .ptr1_msb, .cycle_strobe, .decoded,
        .nop_cycle);
    fetch_model u_fetch (.core_clk, .cycle_strobe, .next_word, .instr_word);
    task chk(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h", $time, got);
        end
    endtask
    task run(input logic [13:0] w);
        next_word = w;
        do @(negedge core_clk); while (cycle_strobe !== 1'b1);
    endtask
    task t_byte;
        run(14'h077F);
        chk(11'({decoded.file_addr, decoded.wr_acc}), 11'h0FF);
        run(14'h00A5);
        chk(11'({decoded.rd_file, decoded.wr_file}), 11'h003);
    endtask
    task t_bits;
        for (int b = 0; b < 8; b++) begin
            run(14'h1412 | 14'(b << 7));
            chk(11'(decoded.bit_mask), 11'(1 << b));
        end
    endtask
    task t_goto;
        run(14'h2DA5);
        chk(decoded.literal, 11'h5A5);
        chk(11'(nop_cycle), 11'h001);
        run(14'h3000);
        chk(decoded.literal, 11'h000);
        run(14'h3000);
        chk(11'(nop_cycle), 11'h000);
    endtask
    // Bit test with a true skip condition inserts one no-op
    task t_skip;
        skip_true = 1'b1;
        run(14'h1C12);
        chk(11'(nop_cycle), 11'h001);
        skip_true = 1'b0;
        run(14'h3000);
        chk(11'(decoded.two_cycle), 11'h000);
        run(14'h3000);
    endtask
    task t_indirect;
        ptr1_msb = 1'b1;
        run(14'h0780);
        chk(11'(decoded.extra_cycle), 11'h000);
        ptr0_msb = 1'b1;
        run(14'h0780);
        chk(11'(decoded.extra_cycle), 11'h001);
    endtask
    task wrap_up;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Reset for six core clocks, then each scenario in turn
    initial begin
        repeat (6) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        run(14'h3000);
        t_byte;
        t_bits;
        t_goto;
        t_skip;
        t_indirect;
        wrap_up;
    end
    // Watchdog, well beyond the expected run
    initial begin
        #20000 failures++;
        wrap_up;
    end
endmodule
`default_nettype wire
